// *** logic/mbo_defs.svh ***
// constants for the memory barrier ordering block
`ifndef MBO_DEFS_SVH
`define MBO_DEFS_SVH
`define MBO_STYPE_MSB 10
`define MBO_STYPE_LSB 6
`define MBO_STYPE_W 5
`define MBO_CODE_FULL 5'h00
`define MBO_CODE_STORE_ORD 5'h04
`define MBO_CODE_FULL_ORD 5'h10
`define MBO_CODE_ACQUIRE 5'h11
`define MBO_CODE_RELEASE 5'h12
`define MBO_CODE_LOAD_ORD 5'h13
`define MBO_CNT_W 6
`define MBO_CNT_ZERO 6'h00
`define MBO_CNT_ONE 6'h01
`endif

// *** logic/mbo_pkg.sv ***
// types shared by the memory barrier ordering block
`include "mbo_defs.svh"
package mbo_pkg;
    // kind of memory operation entering the load/store datapath
    typedef enum logic [2:0] {
        MBO_K_LOAD,
        MBO_K_STORE,
        MBO_K_CACHE,
        MBO_K_PREFETCH_OP,
        MBO_K_INDEXED_PREFETCH_OP,
        MBO_K_FETCH
    } mbo_kind_t;

    // what a decoded barrier waits on and holds back
    typedef struct packed {
        logic wait_ld;
        logic wait_st;
        logic hold_ld;
        logic hold_st;
        logic completion;
    } mbo_sel_t;

    typedef enum logic {
        MBO_IDLE,
        MBO_WAIT
    } mbo_fsm_t;

    typedef struct packed {
        mbo_fsm_t fsm;
        mbo_sel_t sel;
        logic [`MBO_CNT_W-1:0] ld_unord;
        logic [`MBO_CNT_W-1:0] st_unord;
        logic [`MBO_CNT_W-1:0] ld_open;
        logic [`MBO_CNT_W-1:0] st_open;
        logic hold_loads;
        logic hold_stores;
        logic busy;
        logic done;
    } mbo_state_t;
endpackage : mbo_pkg

// *** logic/mbo_sel_if.sv ***
// link between barrier control and the type decoder
`timescale 1ns/1ps
`default_nettype none
`include "mbo_defs.svh"
interface mbo_sel_if;
    logic [`MBO_STYPE_W-1:0] stype;
    mbo_pkg::mbo_sel_t sel;
    modport dec (input stype, output sel);
    modport ctl (output stype, input sel);
endinterface : mbo_sel_if
`default_nettype wire

// *** logic/mbo_stype_decode.sv ***
// barrier type field decoder
`timescale 1ns/1ps
`default_nettype none
`include "mbo_defs.svh"
module mbo_stype_decode #(
    parameter bit ORDER_BARRIERS_EN = 1'b1
) (
    mbo_sel_if.dec sif
);
    // map the type code onto wait and hold selections
    always_comb begin
        sif.sel = '{wait_ld: 1'b1, wait_st: 1'b1, hold_ld: 1'b1, hold_st: 1'b1, completion: 1'b1};
        if (ORDER_BARRIERS_EN) begin
            unique case (sif.stype)
                `MBO_CODE_STORE_ORD: begin
                    sif.sel = '{wait_ld: 1'b0, wait_st: 1'b1, hold_ld: 1'b0, hold_st: 1'b1, completion: 1'b0};
                end
                `MBO_CODE_FULL_ORD: begin
                    sif.sel = '{wait_ld: 1'b1, wait_st: 1'b1, hold_ld: 1'b1, hold_st: 1'b1, completion: 1'b0};
                end
                `MBO_CODE_ACQUIRE: begin
                    sif.sel = '{wait_ld: 1'b1, wait_st: 1'b0, hold_ld: 1'b1, hold_st: 1'b1, completion: 1'b0};
                end
                `MBO_CODE_RELEASE: begin
                    sif.sel = '{wait_ld: 1'b1, wait_st: 1'b1, hold_ld: 1'b0, hold_st: 1'b1, completion: 1'b0};
                end
                `MBO_CODE_LOAD_ORD: begin
                    sif.sel = '{wait_ld: 1'b1, wait_st: 1'b0, hold_ld: 1'b1, hold_st: 1'b0, completion: 1'b0};
                end
                default: begin
                    sif.sel = '{wait_ld: 1'b1, wait_st: 1'b1, hold_ld: 1'b1, hold_st: 1'b1, completion: 1'b1};
                end
            endcase
        end
    end

endmodule : mbo_stype_decode
`default_nettype wire

// *** logic/mbo_barrier.sv ***
// memory barrier ordering control, top level
`timescale 1ns/1ps
`default_nettype none
`include "mbo_defs.svh"
module mbo_barrier #(
    parameter bit ORDER_BARRIERS_EN = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic barrier_req,
    input wire logic [31:0] barrier_instr,
    input wire logic issue_valid,
    input wire mbo_pkg::mbo_kind_t issue_kind,
    input wire logic issue_sync,
    input wire logic ld_ordered,
    input wire logic st_ordered,
    input wire logic ld_written,
    input wire logic st_global,
    output logic hold_loads,
    output logic hold_stores,
    output logic barrier_busy,
    output logic barrier_done
);
    mbo_pkg::mbo_state_t st;
    mbo_pkg::mbo_state_t next_st;
    mbo_sel_if sif ();
    logic is_ld;
    logic is_st;
    logic old_ld_ok;
    logic old_st_ok;
    logic cond_met;

    // type field goes to the decoder
    assign sif.stype = barrier_instr[`MBO_STYPE_MSB:`MBO_STYPE_LSB];

    mbo_stype_decode #(
        .ORDER_BARRIERS_EN(ORDER_BARRIERS_EN)
    ) u_decode (
        .sif(sif.dec)
    );

    // codes without a behaviour of their own must fall back to the full barrier
    a_other_codes_full: assert property (@(posedge clock) disable iff (!resetn)
        (sif.stype != `MBO_CODE_STORE_ORD && sif.stype != `MBO_CODE_FULL_ORD && sif.stype != `MBO_CODE_ACQUIRE
         && sif.stype != `MBO_CODE_RELEASE && sif.stype != `MBO_CODE_LOAD_ORD) |-> sif.sel.completion
         && sif.sel.wait_ld && sif.sel.wait_st && sif.sel.hold_ld && sif.sel.hold_st)
        else $error("unassigned barrier type did not decode as full barrier");

    // classify an issued op; only synchronizable traffic is tracked
    always_comb begin
        is_ld = 1'b0;
        is_st = 1'b0;
        if (issue_valid && issue_sync) begin
            unique case (issue_kind)
                mbo_pkg::MBO_K_LOAD: is_ld = 1'b1;
                mbo_pkg::MBO_K_STORE: is_st = 1'b1;
                mbo_pkg::MBO_K_CACHE: is_st = 1'b1;
                mbo_pkg::MBO_K_PREFETCH_OP: is_ld = 1'b1;
                mbo_pkg::MBO_K_INDEXED_PREFETCH_OP: is_ld = 1'b1;
                mbo_pkg::MBO_K_FETCH: is_ld = 1'b0;
                default: is_ld = 1'b0;
            endcase
        end
    end

    // barrier condition on the tracked older operations
    always_comb begin
        if (st.sel.completion) begin
            old_ld_ok = !st.sel.wait_ld || st.ld_open == `MBO_CNT_ZERO;
            old_st_ok = !st.sel.wait_st || st.st_open == `MBO_CNT_ZERO;
        end else begin
            old_ld_ok = !st.sel.wait_ld || st.ld_unord == `MBO_CNT_ZERO;
            old_st_ok = !st.sel.wait_st || st.st_unord == `MBO_CNT_ZERO;
        end
        cond_met = old_ld_ok && old_st_ok;
    end

    // adjust a counter by one increment and one decrement
    function automatic logic [`MBO_CNT_W-1:0] bump(input logic [`MBO_CNT_W-1:0] c, input logic up,
                                                   input logic down);
        logic [`MBO_CNT_W-1:0] r;
        r = c;
        if (up && !down) begin
            r = c + `MBO_CNT_ONE;
        end else if (down && !up) begin
            r = c - `MBO_CNT_ONE;
        end
        return r;
    endfunction : bump

    // next state: counters always track, fsm takes and releases barriers
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.ld_unord = bump(st.ld_unord, is_ld, ld_ordered);
        next_st.st_unord = bump(st.st_unord, is_st, st_ordered);
        next_st.ld_open = bump(st.ld_open, is_ld, ld_written);
        next_st.st_open = bump(st.st_open, is_st, st_global);
        unique case (st.fsm)
            mbo_pkg::MBO_IDLE: begin
                if (barrier_req) begin
                    next_st.fsm = mbo_pkg::MBO_WAIT;
                    next_st.sel = sif.sel;
                    next_st.hold_loads = sif.sel.hold_ld;
                    next_st.hold_stores = sif.sel.hold_st;
                    next_st.busy = 1'b1;
                end
            end
            mbo_pkg::MBO_WAIT: begin
                if (cond_met) begin
                    next_st.fsm = mbo_pkg::MBO_IDLE;
                    next_st.hold_loads = 1'b0;
                    next_st.hold_stores = 1'b0;
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                end
            end
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '{fsm: mbo_pkg::MBO_IDLE, sel: '0, ld_unord: `MBO_CNT_ZERO, st_unord: `MBO_CNT_ZERO,
                    ld_open: `MBO_CNT_ZERO, st_open: `MBO_CNT_ZERO, hold_loads: 1'b0, hold_stores: 1'b0,
                    busy: 1'b0, done: 1'b0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign hold_loads = st.hold_loads;
    assign hold_stores = st.hold_stores;
    assign barrier_busy = st.busy;
    assign barrier_done = st.done;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence s_req_taken;
        clk_en && st.fsm == mbo_pkg::MBO_IDLE && barrier_req;
    endsequence

    sequence s_cond_seen;
        clk_en && st.fsm == mbo_pkg::MBO_WAIT && cond_met;
    endsequence

    sequence s_still_waiting;
        clk_en && st.fsm == mbo_pkg::MBO_WAIT && !cond_met;
    endsequence

    // one barrier: taken, held, then released with a single done pulse
    a_hold_after_req: assert property (s_req_taken |=> hold_loads == $past(sif.sel.hold_ld)
        && hold_stores == $past(sif.sel.hold_st) && barrier_busy)
        else $error("holds not raised after barrier taken");

    a_done_needs_cond: assert property ($rose(barrier_done) |-> $past(cond_met)
        && $past(st.fsm) == mbo_pkg::MBO_WAIT)
        else $error("barrier released without condition");

    a_no_early_done: assert property (clk_en && st.fsm == mbo_pkg::MBO_WAIT && !cond_met |=> !barrier_done)
        else $error("barrier released while older ops pending");

    a_holds_stand: assert property (s_still_waiting |=> $stable(hold_loads) && $stable(hold_stores)
        && barrier_busy)
        else $error("holds dropped while barrier still waiting");

    a_release_holds: assert property (s_cond_seen |=> barrier_done && !hold_loads && !hold_stores
        && !barrier_busy)
        else $error("holds not dropped on release");

    a_done_one_cycle: assert property (barrier_done && clk_en |=> !barrier_done)
        else $error("done pulse longer than one cycle");

    // a barrier passes only once its selected older counts are clear
    a_completion_waits: assert property (s_cond_seen ##0 st.sel.completion |->
        (st.ld_open == `MBO_CNT_ZERO || !st.sel.wait_ld) && (st.st_open == `MBO_CNT_ZERO || !st.sel.wait_st))
        else $error("completion barrier passed with open older ops");

    a_ordering_waits: assert property (s_cond_seen ##0 !st.sel.completion |->
        (st.ld_unord == `MBO_CNT_ZERO || !st.sel.wait_ld) && (st.st_unord == `MBO_CNT_ZERO || !st.sel.wait_st))
        else $error("ordering barrier passed with unordered older ops");

    // counters follow issues and datapath events
    a_load_count_up: assert property (clk_en && is_ld && !ld_written |=>
        st.ld_open == $past(st.ld_open) + `MBO_CNT_ONE)
        else $error("load open count did not rise");

    a_store_count_up: assert property (clk_en && is_st && !st_global |=>
        st.st_open == $past(st.st_open) + `MBO_CNT_ONE)
        else $error("store open count did not rise");

    a_load_order_down: assert property (clk_en && ld_ordered && !is_ld |=>
        st.ld_unord == $past(st.ld_unord) - `MBO_CNT_ONE)
        else $error("load unordered count did not fall");

    a_unsync_ignored: assert property (clk_en && issue_valid && !issue_sync && !ld_ordered && !st_ordered
        |=> st.ld_unord == $past(st.ld_unord) && st.st_unord == $past(st.st_unord))
        else $error("non-synchronizable access tracked");

    a_fetch_ignored: assert property (clk_en && issue_valid && issue_kind == mbo_pkg::MBO_K_FETCH
        && !ld_ordered && !st_ordered && !ld_written && !st_global |=> $stable(st.ld_open)
        && $stable(st.st_open) && $stable(st.ld_unord) && $stable(st.st_unord))
        else $error("instruction fetch was tracked");

    // selections decoded for the defined codes
    a_full_code_full: assert property (sif.stype == `MBO_CODE_FULL |-> sif.sel.completion
        && sif.sel.wait_ld && sif.sel.wait_st && sif.sel.hold_ld && sif.sel.hold_st)
        else $error("type zero did not decode as full barrier");

    a_order_codes: assert property (ORDER_BARRIERS_EN && (sif.stype == `MBO_CODE_STORE_ORD
        || sif.stype == `MBO_CODE_FULL_ORD || sif.stype == `MBO_CODE_LOAD_ORD) |-> !sif.sel.completion
        && sif.sel.wait_ld == (sif.stype != `MBO_CODE_STORE_ORD)
        && sif.sel.wait_st == (sif.stype != `MBO_CODE_LOAD_ORD)
        && sif.sel.hold_ld == sif.sel.wait_ld && sif.sel.hold_st == sif.sel.wait_st)
        else $error("ordering code decoded with wrong selection");

    a_acquire_code: assert property (ORDER_BARRIERS_EN && sif.stype == `MBO_CODE_ACQUIRE |->
        !sif.sel.completion && sif.sel.wait_ld && !sif.sel.wait_st && sif.sel.hold_ld && sif.sel.hold_st)
        else $error("acquire code decoded with wrong selection");

    a_release_code: assert property (ORDER_BARRIERS_EN && sif.stype == `MBO_CODE_RELEASE |->
        !sif.sel.completion && sif.sel.wait_ld && sif.sel.wait_st && !sif.sel.hold_ld && sif.sel.hold_st)
        else $error("release code decoded with wrong selection");

    // nothing moves while the clock enable is low
    a_freeze_state: assert property (!clk_en |=> st == $past(st))
        else $error("state moved while clock enable low");
endmodule : mbo_barrier
`default_nettype wire

// *** testbench/mbo_lsu_model.sv ***
// behavioural load/store datapath that orders and completes tracked ops
`timescale 1ns/1ps
`default_nettype none
module mbo_lsu_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic issue_valid,
    input wire mbo_pkg::mbo_kind_t issue_kind,
    input wire logic issue_sync,
    input wire logic ord_en,
    input wire logic done_en,
    output logic ld_ordered,
    output logic st_ordered,
    output logic ld_written,
    output logic st_global
);
    int lo;
    int so;
    int lw;
    int sg;
    // each cycle: finish one op per class, order one, then accept the new op
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lo = 0;
            so = 0;
            lw = 0;
            sg = 0;
            ld_ordered <= 1'b0;
            st_ordered <= 1'b0;
            ld_written <= 1'b0;
            st_global <= 1'b0;
        end else begin
            ld_written <= done_en && lw > 0;
            st_global <= done_en && sg > 0;
            if (done_en && lw > 0) lw--;
            if (done_en && sg > 0) sg--;
            ld_ordered <= ord_en && lo > 0;
            st_ordered <= ord_en && so > 0;
            if (ord_en && lo > 0) begin
                lo--;
                lw++;
            end
            if (ord_en && so > 0) begin
                so--;
                sg++;
            end
            // only synchronizable ops are reported; fetches never
            if (issue_valid && issue_sync) begin
                case (issue_kind)
                    mbo_pkg::MBO_K_STORE, mbo_pkg::MBO_K_CACHE: so++;
                    mbo_pkg::MBO_K_FETCH: ;
                    default: lo++;
                endcase
            end
        end
    end
endmodule : mbo_lsu_model
`default_nettype wire

// *** testbench/tb_mbo_barrier.sv ***
// self-checking bench for the memory barrier ordering block
`timescale 1ns/1ps
`default_nettype none
module tb_mbo_barrier;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic barrier_req = 1'b0;
    logic [31:0] barrier_instr = 32'h0000_0000;
    logic issue_valid = 1'b0;
    mbo_pkg::mbo_kind_t issue_kind = mbo_pkg::MBO_K_LOAD;
    logic issue_sync = 1'b0;
    logic ord_en = 1'b0;
    logic done_en = 1'b0;
    logic clk_en = 1'b1;
    logic ld_ordered, st_ordered, ld_written, st_global;
    logic hold_loads, hold_stores, barrier_busy, barrier_done;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    mbo_barrier uut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .barrier_req(barrier_req),
        .barrier_instr(barrier_instr), .issue_valid(issue_valid), .issue_kind(issue_kind),
        .issue_sync(issue_sync), .ld_ordered(ld_ordered), .st_ordered(st_ordered),
        .ld_written(ld_written), .st_global(st_global), .hold_loads(hold_loads),
        .hold_stores(hold_stores), .barrier_busy(barrier_busy), .barrier_done(barrier_done));

    mbo_lsu_model lsu (.clock(clock), .resetn(resetn), .issue_valid(issue_valid),
        .issue_kind(issue_kind), .issue_sync(issue_sync), .ord_en(ord_en), .done_en(done_en),
        .ld_ordered(ld_ordered), .st_ordered(st_ordered), .ld_written(ld_written),
        .st_global(st_global));

    // clock and hang limit
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic issue(input mbo_pkg::mbo_kind_t kind, input logic sync);
        @(negedge clock);
        issue_valid = 1'b1;
        issue_kind = kind;
        issue_sync = sync;
        @(negedge clock);
        issue_valid = 1'b0;
    endtask : issue

    // present a barrier; surrounding bits set so only 10:6 may matter
    task automatic start(input logic [4:0] code);
        @(negedge clock);
        barrier_req = 1'b1;
        barrier_instr = 32'hFFFF_F83F | {21'h0, code, 6'h00};
    endtask : start

    // watch for the done pulse and drop the request in its cycle
    task automatic wait_done(input int n, inout logic seen);
        repeat (n) begin
            @(negedge clock);
            if (barrier_done === 1'b1) begin
                seen = 1'b1;
                barrier_req = 1'b0;
                break;
            end
        end
    endtask : wait_done

    // six defined codes and two unassigned ones: holds, ordering-only release, completion release
    task automatic sc_codes();
        logic [4:0] codes [8] = '{5'h04, 5'h10, 5'h11, 5'h12, 5'h13, 5'h00, 5'h01, 5'h14};
        logic [1:0] hold;
        logic ordb;
        logic seen;
        foreach (codes[i]) begin
            ordb = codes[i] inside {5'h04, 5'h10, 5'h11, 5'h12, 5'h13};
            case (codes[i])
                5'h04, 5'h12: hold = 2'b01;
                5'h13: hold = 2'b10;
                default: hold = 2'b11;
            endcase
            ord_en = 1'b0;
            done_en = 1'b0;
            issue(mbo_pkg::MBO_K_LOAD, 1'b1);
            issue(mbo_pkg::MBO_K_STORE, 1'b1);
            start(codes[i]);
            repeat (3) @(negedge clock);
            check("busy", {4'h0, barrier_busy}, 5'h01);
            check("holds", {3'h0, hold_loads, hold_stores}, {3'h0, hold});
            ord_en = 1'b1;
            seen = 1'b0;
            wait_done(12, seen);
            check("early done", {4'h0, seen}, {4'h0, ordb});
            done_en = 1'b1;
            if (!seen) wait_done(20, seen);
            check("done", {4'h0, seen}, 5'h01);
            @(negedge clock);
            check("idle", {1'b0, hold_loads, hold_stores, barrier_busy, barrier_done}, 5'h00);
            repeat (6) @(negedge clock);
        end
    endtask : sc_codes

    // cache and prefetch ops hold a barrier; fetches and unsync ops do not
    task automatic sc_kinds();
        mbo_pkg::mbo_kind_t kinds [6] = '{mbo_pkg::MBO_K_CACHE, mbo_pkg::MBO_K_PREFETCH_OP,
            mbo_pkg::MBO_K_INDEXED_PREFETCH_OP, mbo_pkg::MBO_K_FETCH, mbo_pkg::MBO_K_STORE,
            mbo_pkg::MBO_K_LOAD};
        logic syncs [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        logic seen;
        foreach (kinds[i]) begin
            ord_en = 1'b0;
            done_en = 1'b0;
            issue(kinds[i], syncs[i]);
            start(5'h00);
            seen = 1'b0;
            wait_done(10, seen);
            check("unheld done", {4'h0, seen}, {4'h0, i > 2});
            ord_en = 1'b1;
            done_en = 1'b1;
            if (!seen) wait_done(20, seen);
            check("kind done", {4'h0, seen}, 5'h01);
            repeat (4) @(negedge clock);
        end
    endtask : sc_kinds

    // clock enable low: a request is not taken and a done pulse stands
    task automatic sc_freeze();
        logic seen;
        ord_en = 1'b0;
        done_en = 1'b0;
        issue(mbo_pkg::MBO_K_LOAD, 1'b1);
        clk_en = 1'b0;
        start(5'h13);
        repeat (3) @(negedge clock);
        check("frozen busy", {4'h0, barrier_busy}, 5'h00);
        clk_en = 1'b1;
        @(negedge clock);
        check("busy", {4'h0, barrier_busy}, 5'h01);
        ord_en = 1'b1;
        seen = 1'b0;
        wait_done(12, seen);
        check("freeze done", {4'h0, seen}, 5'h01);
        clk_en = 1'b0;
        repeat (3) @(negedge clock);
        check("held done", {4'h0, barrier_done}, 5'h01);
        clk_en = 1'b1;
        done_en = 1'b1;
        @(negedge clock);
        check("done drop", {3'h0, barrier_done, barrier_busy}, 5'h00);
        repeat (6) @(negedge clock);
    endtask : sc_freeze

    // reset in mid-barrier clears all; a request still up is taken afresh
    task automatic sc_reset();
        logic seen;
        ord_en = 1'b0;
        done_en = 1'b0;
        issue(mbo_pkg::MBO_K_STORE, 1'b1);
        start(5'h00);
        repeat (2) @(negedge clock);
        check("busy", {4'h0, barrier_busy}, 5'h01);
        resetn = 1'b0;
        @(negedge clock);
        check("reset outputs", {1'b0, hold_loads, hold_stores, barrier_busy, barrier_done}, 5'h00);
        @(negedge clock);
        resetn = 1'b1;
        seen = 1'b0;
        wait_done(4, seen);
        check("done after reset", {4'h0, seen}, 5'h01);
        repeat (4) @(negedge clock);
    endtask : sc_reset

    // reset, then the scenarios
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        sc_codes();
        sc_kinds();
        sc_freeze();
        sc_reset();
        stop_test();
    end
endmodule : tb_mbo_barrier
`default_nettype wire
